/* verilog/balu_pkg.sv */
// Constants, types and decode helpers of the byte ALU datapath
// Function
// - Add, or add with carry, writes the sum; updates Z C N V H; one clock.
// - Pair plus immediate writes the word back; updates Z C N V S; two clocks.
// - Subtract register or constant stores difference; updates Z C N V H; one clock.
// - Subtract with borrow also deducts carry; updates Z C N V H; one clock.
// - Pair minus immediate writes the word back; updates Z C N V S; two clocks.
// - AND with register or constant; updates only Z N V; one clock.
// - OR with register or constant; updates only Z N V; one clock.
// - Exclusive OR of two registers into destination; updates Z N V; one clock.
// - Bit set ORs a constant mask in; updates Z N V; one clock.
// - Bit clear ANDs with ones minus mask; updates Z N V; one clock.
// - Check ANDs register with itself, value unchanged; flags show contents; one clock.
// - Zeroing XORs register with itself; updates Z N V; one clock.
// - Products land in registers one and zero; update Z C; two clocks.
package balu_pkg;

   // ==========================================================
   // Register map and fields
   localparam logic [7:0] OFS_CMD        = 8'h00;
   localparam logic [7:0] OFS_STATUS     = 8'h04;
   localparam logic [7:0] OFS_RESULT     = 8'h08;
   localparam logic [7:0] OFS_REGS       = 8'h80;
   localparam int         CMD_OP_LSB     = 0;
   localparam int         CMD_RD_LSB     = 5;
   localparam int         CMD_RR_LSB     = 10;
   localparam int         CMD_IMM_LSB    = 16;
   localparam int         STAT_BUSY_BIT  = 0;
   localparam int         STAT_FLAGS_LSB = 8;
   localparam int         FLG_C          = 0;
   localparam int         FLG_Z          = 1;
   localparam int         FLG_N          = 2;
   localparam int         FLG_V          = 3;
   localparam int         FLG_S          = 4;
   localparam int         FLG_H          = 5;

   // ==========================================================
   // Reset values and fixed numbers
   localparam logic [7:0] FLAGS_RST      = 8'h00;
   localparam logic [4:0] REG_IDX_RST    = 5'h00;
   localparam logic [7:0] IMM_RST        = 8'h00;
   localparam logic [4:0] PROD_LO_REG    = 5'h00;
   localparam logic [4:0] PROD_HI_REG    = 5'h01;
   localparam logic [7:0] BYTE_ONES      = 8'hff;

   // ==========================================================
   // Timing
   localparam int         CLK_PERIOD_NS  = 50;
   localparam logic [1:0] OP_CLKS_SHORT  = 2'h1;
   localparam logic [1:0] OP_CLKS_LONG   = 2'h2;

   // ==========================================================
   // Operation and state codes
   typedef enum logic [4:0] {
      OP_ADD                = 5'h00,
      OP_ADD_CARRY          = 5'h01,
      OP_PAIR_PLUS_IMM      = 5'h02,
      OP_SUB                = 5'h03,
      OP_MINUS_CONST        = 5'h04,
      OP_MINUS_BORROW       = 5'h05,
      OP_MINUS_BORROW_CONST = 5'h06,
      OP_PAIR_MINUS_IMM     = 5'h07,
      OP_AND                = 5'h08,
      OP_MASK_CONST         = 5'h09,
      OP_OR                 = 5'h0a,
      OP_MERGE_CONST        = 5'h0b,
      OP_EXCL_DISJ          = 5'h0c,
      OP_BITS_SET           = 5'h0d,
      OP_BITS_CLEAR         = 5'h0e,
      OP_ZERO_SIGN_CHECK    = 5'h0f,
      OP_ZEROING            = 5'h10,
      OP_UNSIGNED_PRODUCT   = 5'h11,
      OP_SIGNED_PRODUCT     = 5'h12
   } balu_op_type;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_EXEC  = 2'b10
   } balu_state_type;

   // ==========================================================
   // Decode helpers
   function automatic logic op_legal(input logic [4:0] code);
      return code <= 5'(OP_SIGNED_PRODUCT);
   endfunction : op_legal

   function automatic logic is_pair(input balu_op_type op);
      return op == OP_PAIR_PLUS_IMM || op == OP_PAIR_MINUS_IMM;
   endfunction : is_pair

   function automatic logic is_prod(input balu_op_type op);
      return op == OP_UNSIGNED_PRODUCT || op == OP_SIGNED_PRODUCT;
   endfunction : is_prod

   function automatic logic uses_imm(input balu_op_type op);
      return op inside {OP_MINUS_CONST, OP_MINUS_BORROW_CONST, OP_MASK_CONST,
                        OP_MERGE_CONST, OP_BITS_SET, OP_BITS_CLEAR};
   endfunction : uses_imm

   function automatic logic [1:0] op_clks(input balu_op_type op);
      return (is_pair(op) || is_prod(op)) ? OP_CLKS_LONG : OP_CLKS_SHORT;
   endfunction : op_clks

endpackage : balu_pkg

/* verilog/balu_regfile.sv */
// Working register file with two registered read ports and one write port
`timescale 1ns/1ns
module balu_regfile #(
   parameter int DW = 8,
   parameter int AW = 5
) (
   input  wire logic          clk,
   input  wire logic [AW-1:0] rd_addr_a,
   input  wire logic [AW-1:0] rd_addr_b,
   output logic      [DW-1:0] rd_data_a,
   output logic      [DW-1:0] rd_data_b,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data
);

   logic [DW-1:0] mem [2**AW];

   // ==========================================================
   // Storage write
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // ==========================================================
   // Registered reads, old data on a same-address write
   always_ff @(posedge clk) begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
   end

endmodule : balu_regfile

/* verilog/balu_top.sv */
// Byte ALU datapath with working registers behind an APB slave
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module balu_top
   import balu_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RESET_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic             PREADY,
   output logic      [31:0] PRDATA,
   output logic             PSLVERR
);

   balu_state_type st;
   balu_state_type next_st;
   balu_op_type    op;
   logic [4:0]     rd;
   logic [4:0]     rr;
   logic [7:0]     imm;
   logic           ex_cnt;
   logic           last;
   logic           busy;
   logic [7:0]     flags;
   logic [7:0]     pend_flags;
   logic [15:0]    result;
   logic [7:0]     a;
   logic [7:0]     b;
   logic [7:0]     opnd;
   logic           cin;
   logic [8:0]     sum9;
   logic [8:0]     dif9;
   logic [16:0]    w17;
   logic [15:0]    prod;
   logic [15:0]    r16;
   logic [7:0]     nf;
   logic [4:0]     rd_addr_a;
   logic [4:0]     rd_addr_b;
   logic           wr_en;
   logic [4:0]     wr_addr;
   logic [7:0]     wr_data;
   logic           acc;
   logic           wr_ok;
   logic           hit_cmd;
   logic           hit_stat;
   logic           hit_res;
   logic           hit_reg;
   logic           err;
   logic [31:0]    rword;

   // ==========================================================
   // Register decode
   assign acc      = PSEL & PENABLE;
   assign busy     = st != ST_IDLE;
   assign hit_cmd  = PADDR == OFS_CMD;
   assign hit_stat = PADDR == OFS_STATUS;
   assign hit_res  = PADDR == OFS_RESULT;
   assign hit_reg  = PADDR[7:2] >= OFS_REGS[7:2] && PADDR[1:0] == 2'h0;
   assign wr_ok    = acc & PREADY & ~PSLVERR & PWRITE;

   // Refuse unmapped, read-only writes, illegal codes, and register-file access or command/status writes while busy
   always_comb begin
      err = !(hit_cmd | hit_stat | hit_res | hit_reg);
      if (PWRITE & hit_res) begin
         err = 1'h1;
      end
      if (PWRITE & hit_cmd & !op_legal(PWDATA[CMD_OP_LSB +: 5])) begin
         err = 1'h1;
      end
      if (busy & (hit_reg | (PWRITE & (hit_cmd | hit_stat)))) begin
         err = 1'h1;
      end
   end

   // Read word selection
   always_comb begin
      rword = 32'h0;
      if (hit_cmd) begin
         rword[CMD_OP_LSB +: 5]  = op;
         rword[CMD_RD_LSB +: 5]  = rd;
         rword[CMD_RR_LSB +: 5]  = rr;
         rword[CMD_IMM_LSB +: 8] = imm;
      end else if (hit_stat) begin
         rword[STAT_BUSY_BIT]      = busy;
         rword[STAT_FLAGS_LSB +: 8] = flags;
      end else if (hit_res) begin
         rword[15:0] = result;
      end else begin
         rword[7:0] = a;
      end
   end

   // ==========================================================
   // APB answer: one wait state on every access
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         PREADY <= 1'h0;
      end else begin
         PREADY <= acc & ~PREADY;
      end
   end

   // Read data and error, loaded in the first access cycle
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         PRDATA  <= 32'h0;
         PSLVERR <= 1'h0;
      end else if (acc & ~PREADY) begin
         PRDATA  <= (err | PWRITE) ? 32'h0 : rword;
         PSLVERR <= err;
      end else if (!acc) begin
         PRDATA  <= 32'h0;
         PSLVERR <= 1'h0;
      end
   end

   // ==========================================================
   // Command latch, started by a write to the command register
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         op  <= OP_ADD;
         rd  <= REG_IDX_RST;
         rr  <= REG_IDX_RST;
         imm <= IMM_RST;
      end else if (wr_ok & hit_cmd) begin
         op  <= balu_op_type'(PWDATA[CMD_OP_LSB +: 5]);
         rd  <= PWDATA[CMD_RD_LSB +: 5];
         rr  <= PWDATA[CMD_RR_LSB +: 5];
         imm <= PWDATA[CMD_IMM_LSB +: 8];
      end
   end

   // ==========================================================
   // Sequencer: fetch operands, then one or two execute clocks
   assign last = ({1'h0, ex_cnt} + 2'h1) == op_clks(op);

   always_comb begin
      next_st = st;
      unique case (st)
         ST_IDLE: begin
            if (wr_ok & hit_cmd) begin
               next_st = ST_FETCH;
            end
         end
         ST_FETCH: begin
            next_st = ST_EXEC;
         end
         ST_EXEC: begin
            if (last) begin
               next_st = ST_IDLE;
            end
         end
         default: begin
            next_st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         st <= ST_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // Execute clock counter
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         ex_cnt <= 1'h0;
      end else begin
         ex_cnt <= (st == ST_EXEC) && !last;
      end
   end

   // ==========================================================
   // Working registers
   assign rd_addr_a = busy ? rd : PADDR[6:2];
   assign rd_addr_b = is_pair(op) ? 5'(rd + 5'h01) : rr;

   balu_regfile #(
      .DW (8),
      .AW (5)
   ) u_regs (
      .clk       (CORE_CLK),
      .rd_addr_a (rd_addr_a),
      .rd_addr_b (rd_addr_b),
      .rd_data_a (a),
      .rd_data_b (b),
      .wr_en     (wr_en),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data)
   );

   // Write port: low byte first clock, high byte second clock
   always_comb begin
      wr_en   = 1'h0;
      wr_addr = PADDR[6:2];
      wr_data = PWDATA[7:0];
      if (st == ST_EXEC) begin
         wr_en = 1'h1;
         if (!ex_cnt) begin
            wr_addr = is_prod(op) ? PROD_LO_REG : rd;
            wr_data = r16[7:0];
         end else begin
            wr_addr = is_prod(op) ? PROD_HI_REG : 5'(rd + 5'h01);
            wr_data = result[15:8];
         end
      end else if (wr_ok & hit_reg) begin
         wr_en = 1'h1;
      end
   end

   // ==========================================================
   // Arithmetic and logic
   assign opnd = uses_imm(op) ? imm : b;
   assign cin  = (op == OP_ADD_CARRY || op == OP_MINUS_BORROW ||
                  op == OP_MINUS_BORROW_CONST) & flags[FLG_C];
   assign sum9 = {1'h0, a} + {1'h0, opnd} + {8'h0, cin};
   assign dif9 = {1'h0, a} - {1'h0, opnd} - {8'h0, cin};
   assign w17  = (op == OP_PAIR_MINUS_IMM) ? {1'h0, b, a} - {9'h0, imm}
                                           : {1'h0, b, a} + {9'h0, imm};
   assign prod = (op == OP_SIGNED_PRODUCT) ? 16'($signed(a) * $signed(b))
                                           : 16'(a * b);

   // Result and next flags; untouched flags keep their value
   always_comb begin
      r16 = 16'h0;
      nf  = flags;
      unique case (op)
         OP_ADD, OP_ADD_CARRY: begin
            r16[7:0]  = sum9[7:0];
            nf[FLG_C] = sum9[8];
            nf[FLG_H] = (a[3] & opnd[3]) | (opnd[3] & ~r16[3]) | (~r16[3] & a[3]);
            nf[FLG_V] = (a[7] & opnd[7] & ~r16[7]) | (~a[7] & ~opnd[7] & r16[7]);
         end
         OP_SUB, OP_MINUS_CONST, OP_MINUS_BORROW, OP_MINUS_BORROW_CONST: begin
            r16[7:0]  = dif9[7:0];
            nf[FLG_C] = dif9[8];
            nf[FLG_H] = (~a[3] & opnd[3]) | (opnd[3] & r16[3]) | (r16[3] & ~a[3]);
            nf[FLG_V] = (a[7] & ~opnd[7] & ~r16[7]) | (~a[7] & opnd[7] & r16[7]);
         end
         OP_PAIR_PLUS_IMM, OP_PAIR_MINUS_IMM: begin
            r16       = w17[15:0];
            nf[FLG_C] = w17[16];
            nf[FLG_V] = (op == OP_PAIR_PLUS_IMM) ? ~b[7] & r16[15] : b[7] & ~r16[15];
         end
         OP_AND, OP_MASK_CONST: begin
            r16[7:0]  = a & opnd;
            nf[FLG_V] = 1'h0;
         end
         OP_OR, OP_MERGE_CONST, OP_BITS_SET: begin
            r16[7:0]  = a | opnd;
            nf[FLG_V] = 1'h0;
         end
         OP_EXCL_DISJ: begin
            r16[7:0]  = a ^ b;
            nf[FLG_V] = 1'h0;
         end
         OP_BITS_CLEAR: begin
            r16[7:0]  = a & (BYTE_ONES - opnd);
            nf[FLG_V] = 1'h0;
         end
         OP_ZERO_SIGN_CHECK: begin
            r16[7:0]  = a & a;
            nf[FLG_V] = 1'h0;
         end
         OP_ZEROING: begin
            r16[7:0]  = a ^ a;
            nf[FLG_V] = 1'h0;
         end
         OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT: begin
            r16       = prod;
            nf[FLG_C] = prod[15];
         end
      endcase
      if (is_pair(op) || is_prod(op)) begin
         nf[FLG_Z] = r16 == 16'h0;
      end else begin
         nf[FLG_Z] = r16[7:0] == 8'h00;
      end
      if (is_pair(op)) begin
         nf[FLG_N] = r16[15];
         nf[FLG_S] = r16[15] ^ nf[FLG_V];
      end else if (!is_prod(op)) begin
         nf[FLG_N] = r16[7];
      end
   end

   // ==========================================================
   // Result register, caught in the first execute clock
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         result     <= 16'h0;
         pend_flags <= FLAGS_RST;
      end else if (st == ST_EXEC && !ex_cnt) begin
         result     <= r16;
         pend_flags <= nf;
      end
   end

   // Status flags: commit on the last execute clock, or software write
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         flags <= FLAGS_RST;
      end else if (st == ST_EXEC && last) begin
         flags <= ex_cnt ? pend_flags : nf;
      end else if (wr_ok & hit_stat) begin
         flags <= PWDATA[STAT_FLAGS_LSB +: 8];
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESET_N);

   logic ex0;
   assign ex0 = st == ST_EXEC && !ex_cnt;

   property p_add;
      ex0 && op inside {OP_ADD, OP_ADD_CARRY} |-> wr_en && wr_data == 8'(a + b + cin)
         ##1 st == ST_IDLE && flags[FLG_C] == $past(sum9[8]);
   endproperty
   a_add: assert property (p_add) else $error("add result or timing wrong");

   property p_pair_add;
      ex0 && op == OP_PAIR_PLUS_IMM |-> wr_addr == rd ##1 wr_en
         && wr_addr == 5'(rd + 5'h01) ##1 st == ST_IDLE
         && flags[FLG_S] == (flags[FLG_N] ^ flags[FLG_V]);
   endproperty
   a_pair_add: assert property (p_pair_add) else $error("pair add sequence wrong");

   property p_sub;
      ex0 && op inside {OP_SUB, OP_MINUS_CONST} |-> wr_data == 8'(a - opnd)
         ##1 flags[FLG_C] == ($past(a) < $past(opnd)) && st == ST_IDLE;
   endproperty
   a_sub: assert property (p_sub) else $error("subtract wrong");

   property p_borrow;
      ex0 && op inside {OP_MINUS_BORROW, OP_MINUS_BORROW_CONST}
         |-> wr_data == 8'(a - opnd - {7'h0, flags[FLG_C]}) ##1 st == ST_IDLE;
   endproperty
   a_borrow: assert property (p_borrow) else $error("borrow subtract wrong");

   property p_pair_sub;
      ex0 && op == OP_PAIR_MINUS_IMM |=> wr_addr == 5'(rd + 5'h01)
         && wr_data == result[15:8] ##1 flags[FLG_Z] == (result == 16'h0);
   endproperty
   a_pair_sub: assert property (p_pair_sub) else $error("pair subtract wrong");

   property p_pair_carry;
      ex0 && is_pair(op) && op == OP_PAIR_PLUS_IMM
         |=> result == 16'({$past(b), $past(a)} + {8'h0, $past(imm)});
   endproperty
   a_pair_carry: assert property (p_pair_carry) else $error("pair carry lost");

   property p_and;
      ex0 && op inside {OP_AND, OP_MASK_CONST} |-> wr_data == (a & opnd) ##1 !flags[FLG_V]
         && flags[FLG_C] == $past(flags[FLG_C]) && flags[FLG_H] == $past(flags[FLG_H]);
   endproperty
   a_and: assert property (p_and) else $error("and wrong");

   property p_or;
      ex0 && op inside {OP_OR, OP_MERGE_CONST} |-> wr_data == (a | opnd)
         ##1 flags[FLG_N] == $past(wr_data[7]);
   endproperty
   a_or: assert property (p_or) else $error("or wrong");

   property p_excl;
      ex0 && op == OP_EXCL_DISJ |-> wr_data == (a ^ b) ##1 st == ST_IDLE;
   endproperty
   a_excl: assert property (p_excl) else $error("exclusive or wrong");

   property p_bset;
      ex0 && op == OP_BITS_SET |-> wr_data == (a | imm) && wr_addr == rd;
   endproperty
   a_bset: assert property (p_bset) else $error("bit set wrong");

   property p_bclr;
      ex0 && op == OP_BITS_CLEAR |-> wr_data == (a & ~imm) ##1 !flags[FLG_V];
   endproperty
   a_bclr: assert property (p_bclr) else $error("bit clear wrong");

   property p_check;
      ex0 && op == OP_ZERO_SIGN_CHECK |-> wr_data == a && wr_addr == rd
         ##1 flags[FLG_Z] == ($past(a) == 8'h00);
   endproperty
   a_check: assert property (p_check) else $error("check changed value");

   property p_zeroing;
      ex0 && op == OP_ZEROING |-> wr_data == 8'h00 ##1 flags[FLG_Z] && !flags[FLG_N];
   endproperty
   a_zeroing: assert property (p_zeroing) else $error("zeroing wrong");

   property p_prod;
      ex0 && is_prod(op) |-> wr_addr == PROD_LO_REG ##1 wr_en && wr_addr == PROD_HI_REG
         ##1 st == ST_IDLE && flags[FLG_C] == result[15];
   endproperty
   a_prod: assert property (p_prod) else $error("product placement wrong");

   c_add: cover property (ex0 && op == OP_ADD_CARRY && cin);
   c_pair: cover property (ex0 && op == OP_PAIR_MINUS_IMM ##1 st == ST_EXEC);
   c_prod: cover property (ex0 && op == OP_SIGNED_PRODUCT && prod[15]);
   c_refused: cover property (acc && PREADY && PSLVERR);

endmodule : balu_top

/* sim/balu_apb_master.sv */
// APB master model standing in for the core sequencer
`timescale 1ns/1ns
module balu_apb_master (
   input  wire logic        clk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [7:0]  paddr,
   output logic      [31:0] pwdata
);
   // Idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // One transfer: setup, access held until ready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : balu_apb_master

/* sim/testbench.sv */
// Self-checking bench for the byte ALU datapath over APB
`timescale 1ns/1ns
module testbench
   import balu_pkg::*;
;
   logic        CORE_CLK;
   logic        RESET_N;
   logic        PSEL;
   logic        PENABLE;
   logic        PWRITE;
   logic [7:0]  PADDR;
   logic [31:0] PWDATA;
   logic        PREADY;
   logic [31:0] PRDATA;
   logic        PSLVERR;
   logic [31:0] q;
   int          err_total = 0;
   int          cmp_count = 0;

   // ====
   // Design and bus master
   balu_top u_balu_top (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR));
   balu_apb_master u_balu_apb_master (.clk(CORE_CLK), .pready(PREADY), .prdata(PRDATA),
      .pslverr(PSLVERR), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
      .paddr(PADDR), .pwdata(PWDATA));

   // ====
   // Checking helpers
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      cmp_count++;
      if (got !== ex) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic ee, output logic [31:0] rq);
      logic e;
      u_balu_apb_master.xfer(w, a, d, rq, e);
      chk("bus error", {31'h0, ee}, {31'h0, e});
   endtask : acc

   function automatic logic [7:0] ra(input logic [4:0] n);
      return OFS_REGS | {1'b0, n, 2'b00};
   endfunction : ra

   // Expected result and flags worked out per operation
   function automatic void model(input balu_op_type op, input logic [7:0] a, b, k, f,
                                 output logic [15:0] r, output logic [7:0] fo);
      logic [16:0] w;
      logic [4:0]  h;
      logic [7:0]  y;
      logic        c;
      logic        p;
      fo = f;
      c = f[FLG_C];
      r = 16'h0;
      case (op)
         OP_ADD, OP_ADD_CARRY: begin
            c = c & (op == OP_ADD_CARRY);
            w = a + b + c;
            h = a[3:0] + b[3:0] + c;
            r = {8'h0, w[7:0]};
            fo[FLG_C] = w[8];
            fo[FLG_H] = h[4];
            fo[FLG_V] = a[7] == b[7] && r[7] != a[7];
         end
         OP_SUB, OP_MINUS_CONST, OP_MINUS_BORROW, OP_MINUS_BORROW_CONST: begin
            y = (op == OP_SUB || op == OP_MINUS_BORROW) ? b : k;
            c = c & (op == OP_MINUS_BORROW || op == OP_MINUS_BORROW_CONST);
            w = a - y - c;
            h = a[3:0] - y[3:0] - c;
            r = {8'h0, w[7:0]};
            fo[FLG_C] = w[8];
            fo[FLG_H] = h[4];
            fo[FLG_V] = a[7] != y[7] && r[7] != a[7];
         end
         OP_PAIR_PLUS_IMM, OP_PAIR_MINUS_IMM: begin
            w = (op == OP_PAIR_PLUS_IMM) ? {b, a} + k : {b, a} - k;
            r = w[15:0];
            fo[FLG_C] = w[16];
            fo[FLG_V] = (op == OP_PAIR_PLUS_IMM) ? !b[7] && r[15] : b[7] && !r[15];
         end
         OP_AND: r = a & b;
         OP_MASK_CONST: r = a & k;
         OP_OR: r = a | b;
         OP_MERGE_CONST, OP_BITS_SET: r = a | k;
         OP_EXCL_DISJ: r = a ^ b;
         OP_BITS_CLEAR: r = a & (8'hff - k);
         OP_ZERO_SIGN_CHECK: r = a & a;
         OP_ZEROING: r = a ^ a;
         OP_UNSIGNED_PRODUCT: r = a * b;
         default: r = $signed(a) * $signed(b);
      endcase
      p = op inside {OP_PAIR_PLUS_IMM, OP_PAIR_MINUS_IMM};
      if (op inside {OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT}) begin
         fo[FLG_Z] = r == 16'h0;
         fo[FLG_C] = r[15];
      end else begin
         fo[FLG_Z] = p ? r == 16'h0 : r[7:0] == 8'h0;
         fo[FLG_N] = p ? r[15] : r[7];
         if (op >= OP_AND) fo[FLG_V] = 1'b0;
         if (p) fo[FLG_S] = fo[FLG_N] ^ fo[FLG_V];
      end
   endfunction : model

   // Load operands and flags, run one command, check timing, flags and results
   task automatic run_op(input balu_op_type op, input logic [4:0] rd, rr,
                         input logic [7:0] a, b, k, f);
      logic [31:0] v;
      logic [15:0] r;
      logic [7:0]  fo;
      logic [4:0]  lo;
      logic [4:0]  hi;
      logic        pr;
      logic        pw;
      int          n;
      pr = op inside {OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT};
      pw = op inside {OP_PAIR_PLUS_IMM, OP_PAIR_MINUS_IMM};
      model(op, a, b, k, f, r, fo);
      hi = pr ? 5'h1 : rd + 5'h1;
      lo = pr ? 5'h0 : rd;
      acc(1'b1, ra(pw ? hi : rr), {24'h0, b}, 1'b0, v);
      acc(1'b1, ra(rd), {24'h0, a}, 1'b0, v);
      acc(1'b1, OFS_STATUS, {16'h0, f, 8'h0}, 1'b0, v);
      acc(1'b1, OFS_CMD, {8'h0, k, 1'b0, rr, rd, op}, 1'b0, v);
      acc(1'b0, OFS_STATUS, 32'h0, 1'b0, v);
      chk("busy at first poll", {31'h0, pr | pw}, {31'h0, v[STAT_BUSY_BIT]});
      for (n = 0; n < 8 && v[STAT_BUSY_BIT] !== 1'b0; n++)
         acc(1'b0, OFS_STATUS, 32'h0, 1'b0, v);
      chk("busy cleared", 32'h0, {31'h0, v[STAT_BUSY_BIT]});
      chk("flags", {24'h0, fo}, {24'h0, v[15:8]});
      acc(1'b0, ra(lo), 32'h0, 1'b0, v);
      chk("low byte", {24'h0, r[7:0]}, v);
      if (pr || pw) begin
         acc(1'b0, ra(hi), 32'h0, 1'b0, v);
         chk("high byte", {24'h0, r[15:8]}, v);
      end
      acc(1'b0, OFS_RESULT, 32'h0, 1'b0, v);
      chk("result", {16'h0, r}, v);
      $display("test of op %0d done", op);
   endtask : run_op

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   // ====
   // Clock, reset, watchdog and test sequence
   initial begin
      CORE_CLK = 1'b0;
      forever #(CLK_PERIOD_NS / 2) CORE_CLK = ~CORE_CLK;
   end

   initial begin
      repeat (6000) @(posedge CORE_CLK);
      err_total++;
      end_of_test();
   end

   initial begin
      RESET_N = 1'b0;
      repeat (2) @(posedge CORE_CLK);
      RESET_N <= 1'b1;
      @(posedge CORE_CLK);
      acc(1'b0, OFS_STATUS, 32'h0, 1'b0, q);
      chk("status after reset", 32'h0, q);
      acc(1'b0, 8'h0c, 32'h0, 1'b1, q);
      chk("unmapped read data", 32'h0, q);
      acc(1'b1, OFS_CMD, 32'h13, 1'b1, q);
      acc(1'b1, OFS_RESULT, 32'h1, 1'b1, q);
      acc(1'b1, ra(5'h0), 32'h3, 1'b0, q);
      acc(1'b1, OFS_CMD, {27'h0, OP_UNSIGNED_PRODUCT}, 1'b0, q);
      acc(1'b0, ra(5'h2), 32'h0, 1'b1, q);
      run_op(OP_ADD, 5'h3, 5'h4, 8'h0f, 8'h01, 8'h00, 8'h00);
      run_op(OP_ADD, 5'h3, 5'h4, 8'h80, 8'h80, 8'h00, 8'h10);
      run_op(OP_ADD_CARRY, 5'h5, 5'h6, 8'h7f, 8'h00, 8'h00, 8'h01);
      run_op(OP_SUB, 5'h7, 5'h8, 8'h10, 8'h01, 8'h00, 8'h00);
      run_op(OP_MINUS_CONST, 5'h7, 5'h8, 8'h00, 8'h00, 8'h01, 8'h00);
      run_op(OP_MINUS_BORROW, 5'h9, 5'ha, 8'h80, 8'h00, 8'h00, 8'h01);
      run_op(OP_MINUS_BORROW_CONST, 5'h9, 5'ha, 8'h05, 8'h00, 8'h05, 8'h01);
      run_op(OP_PAIR_PLUS_IMM, 5'h18, 5'h0, 8'hff, 8'h00, 8'h01, 8'h20);
      run_op(OP_PAIR_PLUS_IMM, 5'h1f, 5'h0, 8'hff, 8'h7f, 8'h01, 8'h00);
      run_op(OP_PAIR_PLUS_IMM, 5'h1a, 5'h0, 8'hff, 8'hff, 8'hff, 8'h00);
      run_op(OP_PAIR_MINUS_IMM, 5'h1c, 5'h0, 8'h00, 8'h01, 8'h01, 8'h00);
      run_op(OP_PAIR_MINUS_IMM, 5'h1c, 5'h0, 8'h00, 8'h80, 8'h01, 8'h20);
      run_op(OP_PAIR_MINUS_IMM, 5'h1c, 5'h0, 8'h00, 8'h00, 8'h01, 8'h00);
      run_op(OP_AND, 5'hb, 5'hc, 8'hf0, 8'h3c, 8'h00, 8'h3f);
      run_op(OP_MASK_CONST, 5'hb, 5'hc, 8'h0f, 8'h00, 8'hf0, 8'h3f);
      run_op(OP_OR, 5'hd, 5'he, 8'h80, 8'h01, 8'h00, 8'h3f);
      run_op(OP_MERGE_CONST, 5'hd, 5'he, 8'h00, 8'h00, 8'h00, 8'h00);
      run_op(OP_EXCL_DISJ, 5'hf, 5'h12, 8'haa, 8'haa, 8'h00, 8'h3f);
      run_op(OP_BITS_SET, 5'hf, 5'h12, 8'h01, 8'h00, 8'h80, 8'h3f);
      run_op(OP_BITS_CLEAR, 5'h13, 5'h14, 8'hff, 8'h00, 8'h0f, 8'h3f);
      run_op(OP_ZERO_SIGN_CHECK, 5'h13, 5'h14, 8'h80, 8'h00, 8'h00, 8'h3f);
      run_op(OP_ZEROING, 5'h15, 5'h14, 8'h5a, 8'h00, 8'h00, 8'h3f);
      run_op(OP_UNSIGNED_PRODUCT, 5'h10, 5'h11, 8'hff, 8'hff, 8'h00, 8'h00);
      run_op(OP_UNSIGNED_PRODUCT, 5'h10, 5'h11, 8'h00, 8'h37, 8'h00, 8'h3f);
      run_op(OP_SIGNED_PRODUCT, 5'h10, 5'h11, 8'hff, 8'h01, 8'h00, 8'h00);
      run_op(OP_SIGNED_PRODUCT, 5'h10, 5'h11, 8'h80, 8'h80, 8'h00, 8'h01);
      end_of_test();
   end
endmodule : testbench
